//--- ir_carrier_modulation_timer.sv
// Infrared carrier generator, modulator and capture timer
`timescale 1ns/100ps
// Operation
// R01: Transmit loads count from modulation time and counts down; receive counts up.
// R02: Count wrap from all ones to zero sets overflow flag and interrupt.
// R03: Carrier high lasts high byte plus one, low lasts low byte plus one.
// R04: Input clock is system clock divided by two to the divider field.
// R05: Carrier period, polarity and data bit latched at each interval start.
// R06: Fine clock select picks carrier cycles or input clocks for down count.
// R07: Enabled output idles at the polarity bit level.
// R08: Data one drives carrier, inverted by polarity; data zero holds idle.
// R09: Transmission starts when enable and transmit mode both become set.
// R10: After count reaches zero: reload, resample, drive, set timer flag.
// R11: Switching to receive or clearing enable stops transmission.
// R12: Each interval lasts modulation time plus one counter clocks.
// R13: Receive edge select field chooses qualifying receive edges.
// R14: Receive starts counting from zero at the first qualified edge.
// R15: Later edges store level, capture count, optionally clear count.
// R16: Standard receive sets the timer flag on each capture.
// R17: Receive continues and flags overflow until transmit or disable.
// R18: Burst count mode stops capture; modulation time counts edges.
// R19: Burst mode sets timer flag after two carrier periods without edges.
// R20: Burst mode turning on sets modulation time to one.
// R21: In burst mode fine clock and reload-on-capture still apply.
// R22: While disabled, output level and enable follow power control bits.
// R23: Edge codes: none, falling, rising, both.
// R24: Flags stay until cleared; interrupt is enable gated OR of flags.
module ir_carrier_modulation_timer
  import ir_timer_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic              i_rx,
  output logic [15:0]            o_rdata,
  output logic                   o_tx,
  output logic                   o_tx_oe,
  output logic                   o_irq
);

  state_t   q;
  state_t   n;
  bus_req_t req;
  logic     tick;
  logic     car_end;
  logic     cnt_clk;
  logic     qedge;
  logic     run_tx;
  logic     run_rx;
  ctrl_t    wctrl;

  // Mask of prescaler bits that must be all ones for an input clock
  function automatic logic [6:0] div_mask(input logic [2:0] d);
    div_mask = PRESC_FULL >> (DIV_MAX - d);
  endfunction

  // Qualified edge for a given edge select code
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       prev,
                                    input logic       cur);
    edge_hit = (sel[0] & prev & ~cur) | (sel[1] & ~prev & cur);
  endfunction

  // Request bundle and mode decode
  assign req    = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign wctrl  = ctrl_t'(i_wdata);
  assign run_tx = q.ctrl.timer_enable_bit & q.ctrl.transmit_mode_bit;
  assign run_rx = q.ctrl.timer_enable_bit & ~q.ctrl.transmit_mode_bit;

  // Input clock strobe from the power-of-two prescaler
  assign tick = q.ctrl.timer_enable_bit &&
    ((q.presc & div_mask(q.ctrl.clock_divider_field)) ==
     div_mask(q.ctrl.clock_divider_field));                    // [R04]

  // End of a carrier low phase closes one carrier cycle
  assign car_end = tick && (q.car_cnt == 8'h00) && !q.car_high;
  assign cnt_clk = q.ctrl.fine_clock_select ? tick : car_end;  // [R06] [R21]
  assign qedge   = run_rx &&
    edge_hit(q.ctrl.receive_edge_select, q.rx_prev, i_rx);     // [R13] [R23]

  // Next state of the whole timer
  always_comb begin
    logic [15:0] per;
    per = (q.st == ST_TX) ? q.lat_period : q.carrier_period;
    n = q;
    n.rx_prev = i_rx;
    n.presc = q.ctrl.timer_enable_bit ? q.presc + 7'h01 : 7'h00;

    // Register reads, answered one cycle later
    n.rdata = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        ADDR_CARRIER: n.rdata = q.carrier_period;
        ADDR_COUNT:   n.rdata = q.count_value;
        ADDR_MODTIME: n.rdata = q.modulation_time;
        ADDR_CTRL:    n.rdata = q.ctrl;
        ADDR_STATUS:  n.rdata = {14'h0000, q.overflow_flag, q.timer_flag};
        ADDR_POWER:   n.rdata = {14'h0000, q.manual_output_enable,
                                 q.manual_output_level};
        default:      n.rdata = 16'h0000;
      endcase
    end

    // Register writes; flags are write one to clear
    if (req.wr) begin
      case (req.addr)
        ADDR_CARRIER: n.carrier_period = req.wdata;
        ADDR_COUNT:   n.count_value = req.wdata;
        ADDR_MODTIME: n.modulation_time = req.wdata;
        ADDR_CTRL:    n.ctrl = {3'h0, wctrl[12:0]};
        ADDR_STATUS: begin
          if (req.wdata[STAT_TIMER_BIT]) n.timer_flag = 1'b0;
          if (req.wdata[STAT_OVF_BIT]) n.overflow_flag = 1'b0;
        end
        ADDR_POWER: begin
          n.manual_output_level  = req.wdata[PWR_LEVEL_BIT];
          n.manual_output_enable = req.wdata[PWR_OE_BIT];
        end
        default: ;
      endcase
    end

    // Carrier generator: high phase then low phase
    if (!q.ctrl.timer_enable_bit) begin
      n.car_high = 1'b1;
      n.car_cnt  = q.carrier_period[15:8];
    end else if (tick) begin
      if (q.car_cnt != 8'h00) begin
        n.car_cnt = q.car_cnt - 8'h01;
      end else if (q.car_high) begin
        n.car_high = 1'b0;
        n.car_cnt  = per[7:0];                                 // [R03]
      end else begin
        n.car_high = 1'b1;
        n.car_cnt  = per[15:8];                                // [R03]
      end
    end

    // Mode sequencing
    case (q.st)
      ST_IDLE, ST_RX_WAIT, ST_RX_RUN: begin
        if (run_tx) begin
          n.st          = ST_TX;                               // [R09]
          n.count_value = q.modulation_time;                   // [R01]
          n.lat_period  = q.carrier_period;                    // [R05]
          n.lat_data    = q.ctrl.transmit_data_bit;
          n.lat_pol     = q.ctrl.transmit_polarity;
          n.car_high    = 1'b1;
          n.car_cnt     = q.carrier_period[15:8];
        end else if (!run_rx) begin
          n.st = ST_IDLE;
        end else if (q.st == ST_IDLE) begin
          n.st = ST_RX_WAIT;
        end else if (q.st == ST_RX_WAIT) begin
          if (qedge) begin
            n.st          = ST_RX_RUN;
            n.count_value = COUNT_ZERO;                        // [R14]
            n.space_cnt   = 2'h0;
            n.space_done  = 1'b0;
            if (q.ctrl.burst_count_mode) begin
              n.modulation_time = q.modulation_time + 16'h0001;
            end
          end
        end else begin
          // Up count with capture or burst edge counting
          if (cnt_clk) begin
            n.count_value = q.count_value + 16'h0001;          // [R01]
            if (q.count_value == COUNT_ALL_ONES) begin
              n.overflow_flag = 1'b1;                          // [R02] [R17]
            end
          end
          if (qedge) begin
            n.space_cnt  = 2'h0;
            n.space_done = 1'b0;
            if (q.ctrl.burst_count_mode) begin
              n.modulation_time = q.modulation_time + 16'h0001; // [R18]
            end else begin
              n.ctrl.transmit_data_bit = i_rx;                 // [R15]
              n.modulation_time        = q.count_value;
              n.timer_flag             = 1'b1;                 // [R16]
            end
            if (q.ctrl.reload_on_capture) begin
              n.count_value = COUNT_ZERO;                      // [R15] [R21]
            end
          end else if (q.ctrl.burst_count_mode && car_end &&
                       !q.space_done) begin
            n.space_cnt = q.space_cnt + 2'h1;
            if (q.space_cnt + 2'h1 == SPACE_PERIODS) begin
              n.timer_flag = 1'b1;                             // [R19]
              n.space_done = 1'b1;
            end
          end
        end
      end
      ST_TX: begin
        if (!run_tx) begin
          n.st = run_rx ? ST_RX_WAIT : ST_IDLE;                // [R11]
        end else if (cnt_clk) begin
          if (q.count_value == COUNT_ZERO) begin
            n.count_value = q.modulation_time;                 // [R10] [R12]
            n.lat_period  = q.carrier_period;                  // [R05]
            n.lat_data    = q.ctrl.transmit_data_bit;
            n.lat_pol     = q.ctrl.transmit_polarity;
            n.timer_flag  = 1'b1;                              // [R10]
          end else begin
            n.count_value = q.count_value - 16'h0001;          // [R01]
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // Burst mode switched on loads modulation time with one
    if (req.wr && req.addr == ADDR_CTRL && wctrl.burst_count_mode &&
        !q.ctrl.burst_count_mode) begin
      n.modulation_time = BURST_START;                         // [R20]
    end

    // Transmit pin drive
    if (!n.ctrl.timer_enable_bit) begin
      n.tx_out = n.manual_output_level;                        // [R22]
      n.tx_oe  = n.manual_output_enable;
    end else if (n.st == ST_TX) begin
      n.tx_out = n.lat_data ? (n.car_high ^ n.lat_pol) : n.lat_pol; // [R08]
      n.tx_oe  = 1'b1;
    end else begin
      n.tx_out = n.ctrl.transmit_polarity;                     // [R07]
      n.tx_oe  = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= STATE_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign o_rdata = q.rdata;
  assign o_tx    = q.tx_out;
  assign o_tx_oe = q.tx_oe;
  assign o_irq   = q.ctrl.irq_en &
                   (q.timer_flag | q.overflow_flag);           // [R24]

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic cnt_wr;
  assign cnt_wr = req.wr && (req.addr == ADDR_COUNT);

  sequence s_tx_zero;
    q.st == ST_TX && run_tx && cnt_clk && q.count_value == COUNT_ZERO;
  endsequence
  sequence s_tx_reloaded;
    q.timer_flag && q.lat_data == $past(q.ctrl.transmit_data_bit);
  endsequence

  property p_tx_reload;
    s_tx_zero |=> s_tx_reloaded;
  endproperty
  a_tx_reload: assert property (p_tx_reload) // [R10]
    else $error("transmit interval end did not reload");

  property p_tx_down;
    q.st == ST_TX && run_tx && cnt_clk && q.count_value != COUNT_ZERO
      && !cnt_wr |=> q.count_value == $past(q.count_value) - 16'h0001;
  endproperty
  a_tx_down: assert property (p_tx_down) // [R01]
    else $error("transmit count did not decrement");

  property p_start;
    run_tx && q.st != ST_TX |=> q.st == ST_TX &&
      q.count_value == $past(q.modulation_time);
  endproperty
  a_start: assert property (p_start) // [R09]
    else $error("transmission did not start");

  property p_ovf;
    q.st == ST_RX_RUN && run_rx && cnt_clk && !qedge &&
      q.count_value == COUNT_ALL_ONES |=> q.overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) // [R02]
    else $error("overflow flag missed on wrap");

  property p_capture;
    q.st == ST_RX_RUN && qedge && !q.ctrl.burst_count_mode &&
      !(req.wr && req.addr == ADDR_MODTIME) &&
      !(req.wr && req.addr == ADDR_CTRL && wctrl.burst_count_mode) |=>
      q.modulation_time == $past(q.count_value) && q.timer_flag;
  endproperty
  a_capture: assert property (p_capture) // [R15]
    else $error("capture did not store count");

  property p_burst_on;
    req.wr && req.addr == ADDR_CTRL && wctrl.burst_count_mode &&
      !q.ctrl.burst_count_mode |=> q.modulation_time == BURST_START;
  endproperty
  a_burst_on: assert property (p_burst_on) // [R20]
    else $error("burst mode entry did not load one");

  property p_manual;
    !q.ctrl.timer_enable_bit |->
      o_tx == q.manual_output_level && o_tx_oe == q.manual_output_enable;
  endproperty
  a_manual: assert property (p_manual) // [R22]
    else $error("disabled output not under manual control");

  property p_idle;
    q.st == ST_TX && q.ctrl.timer_enable_bit && !q.lat_data |->
      o_tx == q.lat_pol && o_tx_oe;
  endproperty
  a_idle: assert property (p_idle) // [R07]
    else $error("idle level does not follow polarity");

  property p_carrier;
    q.st == ST_TX && q.ctrl.timer_enable_bit && q.lat_data |->
      o_tx == (q.car_high ^ q.lat_pol);
  endproperty
  a_carrier: assert property (p_carrier) // [R08]
    else $error("carrier not driven on transmit pin");

endmodule

//--- ir_timer_pkg.sv
// Constants, register layout and state types of the infrared carrier timer
package ir_timer_pkg;

  // Register indices on the plain register port
  localparam int          ADDR_W         = 3;
  localparam logic [2:0]  ADDR_CARRIER   = 3'h0;
  localparam logic [2:0]  ADDR_COUNT     = 3'h1;
  localparam logic [2:0]  ADDR_MODTIME   = 3'h2;
  localparam logic [2:0]  ADDR_CTRL      = 3'h3;
  localparam logic [2:0]  ADDR_STATUS    = 3'h4;
  localparam logic [2:0]  ADDR_POWER     = 3'h5;

  // Status and power control bit positions
  localparam int          STAT_TIMER_BIT = 0;
  localparam int          STAT_OVF_BIT   = 1;
  localparam int          PWR_LEVEL_BIT  = 0;
  localparam int          PWR_OE_BIT     = 1;

  // Count values and receive edge select codes
  localparam logic [15:0] COUNT_ZERO     = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] BURST_START    = 16'h0001;
  localparam logic [1:0]  SPACE_PERIODS  = 2'h2;
  localparam logic [1:0]  EDGE_NONE      = 2'h0;
  localparam logic [1:0]  EDGE_FALL      = 2'h1;
  localparam logic [1:0]  EDGE_RISE      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;
  localparam logic [6:0]  PRESC_FULL     = 7'h7F;
  localparam logic [2:0]  DIV_MAX        = 3'h7;

  // Register port request
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic [2:0] spare;
    logic       irq_en;
    logic [2:0] clock_divider_field;
    logic       burst_count_mode;
    logic       reload_on_capture;
    logic [1:0] receive_edge_select;
    logic       fine_clock_select;
    logic       transmit_data_bit;
    logic       transmit_polarity;
    logic       transmit_mode_bit;
    logic       timer_enable_bit;
  } ctrl_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_TX      = 4'h2,
    ST_RX_WAIT = 4'h4,
    ST_RX_RUN  = 4'h8
  } mode_state_t;

  // Whole state of the timer
  typedef struct packed {
    mode_state_t st;
    ctrl_t       ctrl;
    logic [15:0] carrier_period;
    logic [15:0] count_value;
    logic [15:0] modulation_time;
    logic        timer_flag;
    logic        overflow_flag;
    logic        manual_output_level;
    logic        manual_output_enable;
    logic [6:0]  presc;
    logic [7:0]  car_cnt;
    logic        car_high;
    logic [15:0] lat_period;
    logic        lat_data;
    logic        lat_pol;
    logic        rx_prev;
    logic [1:0]  space_cnt;
    logic        space_done;
    logic        tx_out;
    logic        tx_oe;
    logic [15:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{st: ST_IDLE, ctrl: '0, default: '0};

endpackage

//--- ir_link_model.sv
// Far-side model: IR emitter load that times pulses, and IR receiver output
`timescale 1ns/100ps
module ir_link_model (
  input  wire logic i_clk,
  input  wire logic i_tx,
  input  wire logic i_tx_oe,
  output logic      o_rx
);
  int   run;
  int   hi_len;
  int   lo_len;
  logic prev;

  // Receiver output idles high, like a pulled-up demodulator stage
  initial begin
    o_rx = 1'b1;
    run = 0;
    hi_len = 0;
    lo_len = 0;
    prev = 1'b0;
  end

  // Length of the last finished high and low run on the emitter drive
  always @(posedge i_clk) begin
    if (i_tx_oe !== 1'b1 || i_tx !== prev) begin
      if (prev === 1'b1)
        hi_len <= run;
      else
        lo_len <= run;
      run <= 1;
    end else
      run <= run + 1;
    prev <= i_tx;
  end

  // Receiver level change, called just after a rising edge
  task automatic drive(input logic lvl);
    o_rx <= lvl;
  endtask
endmodule

//--- tb_ir_carrier_modulation_timer.sv
// Self-checking bench for the infrared carrier timer
`timescale 1ns/100ps
module tb_ir_carrier_modulation_timer;
  import ir_timer_pkg::*;
  logic              i_clk;
  logic              i_rst_n;
  logic [ADDR_W-1:0] i_addr;
  logic [15:0]       i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic              rx;
  logic [15:0]       o_rdata;
  logic              o_tx;
  logic              o_tx_oe;
  logic              o_irq;
  int                num_errors;
  int                n_tests;
  int                cycles;
  int                eh;
  int                el;
  int                n;
  logic [15:0]       rv;
  logic [15:0]       cap;
  logic [7:0]        car_hi [3] = '{8'h01, 8'h02, 8'h01};
  logic [7:0]        car_lo [3] = '{8'h00, 8'h01, 8'h02};
  logic [2:0]        t_div  [3] = '{3'h0, 3'h1, 3'h0};
  logic              t_fin  [3] = '{1'b1, 1'b0, 1'b1};
  logic              t_pol  [3] = '{1'b0, 1'b0, 1'b1};
  logic [15:0]       t_mt   [3] = '{16'h0005, 16'h0001, 16'h0005};

  ir_carrier_modulation_timer uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_rx(rx), .o_rdata(o_rdata), .o_tx(o_tx),
    .o_tx_oe(o_tx_oe), .o_irq(o_irq));
  ir_link_model far (.i_clk(i_clk), .i_tx(o_tx), .i_tx_oe(o_tx_oe), .o_rx(rx));

  // Clock and hang guard
  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Register port cycles, entered just after a rising edge; the write
  // strobe stays up until the next read or idle wait lowers it
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    i_addr <= a;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    d = o_rdata;
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [15:0] e);
    rd_reg(a, rv);
    check(rv, e, "register");
  endtask

  task automatic ticks(input int k);
    i_wr <= 1'b0;
    repeat (k) @(posedge i_clk);
  endtask

  // Control word; reload on capture and interrupt enable always on
  function automatic logic [15:0] cw(input int en, md, pol, dat, fin,
                                     input int es, bc, dv);
    ctrl_t c;
    c = '0;
    c.timer_enable_bit = en[0];
    c.transmit_mode_bit = md[0];
    c.transmit_polarity = pol[0];
    c.transmit_data_bit = dat[0];
    c.fine_clock_select = fin[0];
    c.receive_edge_select = es[1:0];
    c.reload_on_capture = 1'b1;
    c.burst_count_mode = bc[0];
    c.clock_divider_field = dv[2:0];
    c.irq_en = 1'b1;
    return c;
  endfunction

  initial begin
    i_rst_n = 1'b0;
    i_addr = '0;
    i_wdata = 16'h0000;
    i_rd = 1'b0;
    cycles = 0;
    num_errors = 0;
    n_tests = 0;
    ticks(2);
    i_rst_n <= 1'b1;
    ticks(1);
    // Reset values, unmapped index, read/write registers
    for (int a = 0; a < 7; a++) chk_reg(a[2:0], 16'h0000);
    wr_reg(3'h6, 16'hFFFF);
    chk_reg(3'h6, 16'h0000);
    wr_reg(ADDR_CARRIER, 16'hA55A);
    chk_reg(ADDR_CARRIER, 16'hA55A);
    wr_reg(ADDR_MODTIME, 16'h1234);
    chk_reg(ADDR_MODTIME, 16'h1234);
    // Manual pin control while disabled
    wr_reg(ADDR_POWER, 16'h0003);
    ticks(3);
    check({o_tx, o_tx_oe}, 16'h0003, "manual pin");
    // Carrier shape and interval length for each setting in the table
    for (int k = 0; k < 3; k++) begin
      wr_reg(ADDR_CTRL, 16'h0000);
      wr_reg(ADDR_CARRIER, {car_hi[k], car_lo[k]});
      wr_reg(ADDR_MODTIME, t_mt[k]);
      wr_reg(ADDR_STATUS, 16'h0003);
      wr_reg(ADDR_CTRL, cw(1, 1, t_pol[k], 1, t_fin[k], 0, 0, t_div[k]));
      ticks(60);
      eh = (int'(car_hi[k]) + 1) << t_div[k];
      el = (int'(car_lo[k]) + 1) << t_div[k];
      check(16'(far.hi_len), 16'(t_pol[k] ? el : eh), "high run");
      check(16'(far.lo_len), 16'(t_pol[k] ? eh : el), "low run");
      check({15'h0, o_tx_oe}, 16'h0001, "drive enable");
      // Clear, wait for a fresh flag to align, then time one interval
      wr_reg(ADDR_STATUS, 16'h0001);
      ticks(1);
      n = 0;
      while (o_irq !== 1'b1 && n < 100) begin
        ticks(1);
        n++;
      end
      wr_reg(ADDR_STATUS, 16'h0001);
      n = 1;
      while (n < 100) begin
        ticks(1);
        n++;
        if (o_irq === 1'b1)
          break;
      end
      eh = t_fin[k] ? 1 : (int'(car_hi[k]) + int'(car_lo[k]) + 2);
      check(16'(n), 16'((int'(t_mt[k]) + 1) * (eh << t_div[k])), "interval");
    end
    // Data zero holds the idle level of the polarity
    wr_reg(ADDR_CTRL, cw(1, 1, 1, 0, 1, 0, 0, 0));
    ticks(10);
    check({15'h0, o_tx}, 16'h0001, "idle high");
    ticks(20);
    check({15'h0, o_tx}, 16'h0001, "idle held");
    wr_reg(ADDR_POWER, 16'h0000);
    wr_reg(ADDR_CTRL, cw(0, 1, 1, 0, 1, 0, 0, 0));
    ticks(4);
    check({o_tx, o_tx_oe}, 16'h0000, "stopped");
    // Receive: capture on both edges with reload
    wr_reg(ADDR_STATUS, 16'h0003);
    wr_reg(ADDR_CTRL, cw(1, 0, 0, 0, 1, 2'h3, 0, 0));
    ticks(4);
    far.drive(1'b0);
    ticks(10);
    far.drive(1'b1);
    ticks(3);
    rd_reg(ADDR_MODTIME, cap);
    check(cap, 16'h0009, "first capture");
    chk_reg(ADDR_CTRL, cw(1, 0, 0, 1, 1, 2'h3, 0, 0));
    ticks(6);
    far.drive(1'b0);
    ticks(3);
    rd_reg(ADDR_MODTIME, rv);
    check(rv - cap, 16'h0003, "capture step");
    chk_reg(ADDR_STATUS, 16'h0001);
    // Receive count wraps to zero
    wr_reg(ADDR_CARRIER, 16'h0303);
    wr_reg(ADDR_CTRL, cw(1, 0, 0, 0, 0, 2'h3, 0, 0));
    wr_reg(ADDR_STATUS, 16'h0003);
    wr_reg(ADDR_COUNT, 16'hFFFD);
    wr_reg(ADDR_COUNT, 16'hFFFD);
    ticks(40);
    check({15'h0, o_irq}, 16'h0001, "irq");
    chk_reg(ADDR_STATUS, 16'h0002);
    // No edge selected: no capture
    wr_reg(ADDR_CTRL, 16'h0000);
    wr_reg(ADDR_STATUS, 16'h0003);
    wr_reg(ADDR_CTRL, cw(1, 0, 0, 0, 1, 2'h0, 0, 0));
    far.drive(1'b1);
    ticks(5);
    far.drive(1'b0);
    ticks(5);
    far.drive(1'b1);
    ticks(5);
    chk_reg(ADDR_STATUS, 16'h0000);
    // Burst count: edges counted, space flagged
    wr_reg(ADDR_CARRIER, 16'h0101);
    wr_reg(ADDR_CTRL, cw(1, 0, 0, 0, 1, 2'h3, 0, 0));
    wr_reg(ADDR_CTRL, cw(1, 0, 0, 0, 1, 2'h3, 1, 0));
    chk_reg(ADDR_MODTIME, 16'h0001);
    wr_reg(ADDR_STATUS, 16'h0003);
    for (int e = 0; e < 3; e++) begin
      far.drive(e[0]);
      ticks(2);
    end
    ticks(20);
    chk_reg(ADDR_MODTIME, 16'h0004);
    chk_reg(ADDR_STATUS, 16'h0001);
    stop_test();
  end
endmodule
